/* ostmr_map.svh */
// register offsets, field positions, reset values and clock rates
// assumes a 32-bit word-aligned bus, byte addresses below
`ifndef OSTMR_MAP_SVH
`define OSTMR_MAP_SVH

// byte offsets of the register words
`define OSTMR_OFS_MATCH0 8'h00
`define OSTMR_OFS_MATCH1 8'h04
`define OSTMR_OFS_MATCH2 8'h08
`define OSTMR_OFS_MATCH3 8'h0c
`define OSTMR_OFS_COUNT 8'h10
`define OSTMR_OFS_WDARM 8'h14
`define OSTMR_OFS_FLAGS 8'h18
`define OSTMR_OFS_IRQEN 8'h1c
`define OSTMR_OFS_IMASK 8'h20

// decoded address width in bits
`define OSTMR_ADDR_W 8

// field positions
`define OSTMR_WDARM_BIT 0
`define OSTMR_WD_CHAN 3
`define OSTMR_NCHAN 4

// reset values
`define OSTMR_WDARM_RST 1'h0
`define OSTMR_FLAGS_RST 4'h0
`define OSTMR_IRQEN_RST 4'h0
`define OSTMR_IMASK_RST 4'h0
`define OSTMR_MATCH_RST 32'h0000_0000

// timing: system clock and timer clock rates in hertz
`define OSTMR_SYS_HZ 32'd20000000
`define OSTMR_TMR_HZ 32'd3686400

`endif

/* ostmr_pkg.sv */
// shared types of the match timer
// assumes the map header supplies every number except the four-bit channel width, which is fixed here
package ostmr_pkg;

    // bus slave sequencing
    typedef enum logic {
        OSTMR_BUS_IDLE,
        OSTMR_BUS_DATA
    } ostmr_bus_st_t;

    // one bit per match channel
    typedef logic [3:0] ostmr_chan_t;

endpackage

/* ostmr_tick.sv */
// timer-rate enable generator
// assumes hclk at the system rate; emits one-cycle pulses at the timer rate
`timescale 1ns/10ps
`include "ostmr_map.svh"

module ostmr_tick (
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);

    logic [31:0] acc_q;
    logic [31:0] acc_sum;
    logic wrap;

    // fractional accumulator: average rate is exact, jitter is one hclk
    assign acc_sum = acc_q + `OSTMR_TMR_HZ;
    assign wrap = (acc_sum >= `OSTMR_SYS_HZ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            acc_q <= wrap ? acc_sum - `OSTMR_SYS_HZ : acc_sum;
            tick <= wrap;
        end
    end

endmodule

/* ostmr_ahb_slave.sv */
// ahb-lite slave front end with one wait state per transfer
// assumes single word transfers; answers OKAY to everything
`timescale 1ns/10ps
`include "ostmr_map.svh"

module ostmr_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] rdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic wr_stb,
    output logic [`OSTMR_ADDR_W-1:0] acc_addr
);

    ostmr_pkg::ostmr_bus_st_t st_q;
    logic write_q;
    logic take;

    // nonseq or seq with the bus ready starts an access
    assign take = hsel && htrans[1] && hready;
    assign wr_stb = (st_q == ostmr_pkg::OSTMR_BUS_DATA) && write_q;

    // data phase lasts two cycles so read data leaves a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ostmr_pkg::OSTMR_BUS_IDLE;
            write_q <= 1'b0;
            acc_addr <= '0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
        end else begin
            unique case (st_q)
                ostmr_pkg::OSTMR_BUS_IDLE: begin
                    if (take) begin
                        st_q <= ostmr_pkg::OSTMR_BUS_DATA;
                        write_q <= hwrite;
                        acc_addr <= haddr[`OSTMR_ADDR_W-1:0];
                        hreadyout <= 1'b0;
                    end
                end
                ostmr_pkg::OSTMR_BUS_DATA: begin
                    st_q <= ostmr_pkg::OSTMR_BUS_IDLE;
                    hrdata <= write_q ? 32'h0000_0000 : rdata;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

endmodule

/* ostmr_top.sv */
// match timer with watchdog behind an ahb-lite slave
// assumes one hclk domain at 20 MHz; the timer rate is an enable pulse
//
// Function
// - 32-bit free count advances once per timer clock edge.
// - software may read or load the free count at any time.
// - four 32-bit match values, each writable and readable.
// - after each timer edge compare every match value with the count.
// - each of the four match flags drives an output to interrupts.
// - watchdog arm register bit zero set by writing one.
// - once set, arm ignores writes; cleared by hard, soft reset or sleep.
// - a watchdog reset also clears the arm bit.
// - arm clear gives channel 3 interrupt only; arm set resets the chip.
// - arm bits 31 to 1 reserved; all bits reset to zero.
// - flag set on the edge after the match; cleared by writing one.
// - writing zero to a flag bit leaves it unchanged.
// - flag bits 31 to 4 read zero and ignore writes.
// - flag bits 0 to 3 serve channels 0 to 3; reset value undefined; the code resets them to zero.
// - a match sets a flag only when its enable bit is set.
// - no reset touches the free count.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`include "ostmr_map.svh"

module ostmr_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic software_reset,
    input wire logic sleep_entry,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic [3:0] match_flag,
    output logic irq,
    output logic chip_reset_req
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic tick;
    logic tick_dly_q;
    logic wr_stb;
    logic [`OSTMR_ADDR_W-1:0] acc_addr;
    logic [31:0] rdata;

    logic [31:0] count_q;
    logic [31:0] count_d;
    logic [31:0] match_q [0:3];
    ostmr_pkg::ostmr_chan_t flags_q;
    ostmr_pkg::ostmr_chan_t flags_d;
    ostmr_pkg::ostmr_chan_t irqen_q;
    ostmr_pkg::ostmr_chan_t imask_q;
    logic wdarm_q;
    logic wdarm_d;
    logic wd_fire;

    logic wr_count;
    logic wr_wdarm;
    logic wr_flags;
    logic wr_irqen;
    logic wr_imask;
    ostmr_pkg::ostmr_chan_t wr_match;
    ostmr_pkg::ostmr_chan_t hit;
    ostmr_pkg::ostmr_chan_t set_flag;
    ostmr_pkg::ostmr_chan_t clr_flag;

    logic sel_count;
    logic sel_wdarm;
    logic sel_flags;
    logic sel_irqen;
    logic sel_imask;
    ostmr_pkg::ostmr_chan_t sel_match;

    // byte offset of channel n in the match bank
    function automatic logic [`OSTMR_ADDR_W-1:0] match_ofs(input int n);
        match_ofs = `OSTMR_OFS_MATCH0 + `OSTMR_ADDR_W'(4 * n);
    endfunction

    // widen a four-bit channel field into a zero-filled word
    function automatic logic [31:0] chan_word(input ostmr_pkg::ostmr_chan_t v);
        chan_word = {28'h000_0000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus front end and timer-rate enable

    ostmr_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .rdata(rdata),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .wr_stb(wr_stb),
        .acc_addr(acc_addr)
    );

    ostmr_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    // only word accesses occur; size is not checked
    logic unused_size;
    assign unused_size = ^hsize;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    assign sel_count = (acc_addr == `OSTMR_OFS_COUNT);
    assign sel_wdarm = (acc_addr == `OSTMR_OFS_WDARM);
    assign sel_flags = (acc_addr == `OSTMR_OFS_FLAGS);
    assign sel_irqen = (acc_addr == `OSTMR_OFS_IRQEN);
    assign sel_imask = (acc_addr == `OSTMR_OFS_IMASK);

    genvar gi;
    generate
        for (gi = 0; gi < `OSTMR_NCHAN; gi = gi + 1) begin : g_sel
            assign sel_match[gi] = (acc_addr == match_ofs(gi));
            assign wr_match[gi] = wr_stb && sel_match[gi];
        end
    endgenerate

    // write strobes land in the data phase, when hwdata stands
    assign wr_count = wr_stb && sel_count;
    assign wr_wdarm = wr_stb && sel_wdarm;
    assign wr_flags = wr_stb && sel_flags;
    assign wr_irqen = wr_stb && sel_irqen;
    assign wr_imask = wr_stb && sel_imask;

    ////////////////////////////////////////////////////////////////////////
    // free count

    // a load wins over the timer edge in the same cycle
    assign count_d = wr_count ? hwdata :
                     tick ? count_q + 32'h0000_0001 :
                     count_q;

    // deliberately no reset: the count is unknown until loaded
    always_ff @(posedge hclk) begin
        count_q <= count_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // match values

    // contents are undefined to software; zeroed only to keep x out
    generate
        for (gi = 0; gi < `OSTMR_NCHAN; gi = gi + 1) begin : g_match
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    match_q[gi] <= `OSTMR_MATCH_RST;
                end else if (wr_match[gi]) begin
                    match_q[gi] <= hwdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // compare

    // delayed tick: compare the count as it stands after the edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_dly_q <= 1'b0;
        end else begin
            tick_dly_q <= tick;
        end
    end

    generate
        for (gi = 0; gi < `OSTMR_NCHAN; gi = gi + 1) begin : g_hit
            assign hit[gi] = tick_dly_q && (count_q == match_q[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // match flags

    // gating by enable; the enable never clears a flag already set
    assign set_flag = hit & irqen_q;
    assign clr_flag = wr_flags ? hwdata[3:0] : 4'h0;
    // set wins over a clear in the same cycle, so no match is lost
    assign flags_d = (flags_q & ~clr_flag) | set_flag;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= `OSTMR_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enables and interrupt mask

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqen_q <= `OSTMR_IRQEN_RST;
            imask_q <= `OSTMR_IMASK_RST;
        end else begin
            if (wr_irqen) begin
                irqen_q <= hwdata[3:0];
            end
            if (wr_imask) begin
                imask_q <= hwdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog arm

    // fires on a channel 3 match only while armed
    assign wd_fire = wdarm_q && hit[`OSTMR_WD_CHAN];

    // write-once: a write can only set; clears come from resets and sleep
    assign wdarm_d = (software_reset || sleep_entry || wd_fire) ? 1'b0 :
                     (wr_wdarm && hwdata[`OSTMR_WDARM_BIT]) ? 1'b1 :
                     wdarm_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdarm_q <= `OSTMR_WDARM_RST;
        end else begin
            wdarm_q <= wdarm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // all from flops; irq changes on the same edge as the flag update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_flag <= 4'h0;
            irq <= 1'b0;
            chip_reset_req <= 1'b0;
            hresp <= 1'b0;
        end else begin
            match_flag <= flags_d;
            irq <= |(flags_d & imask_q);
            chip_reset_req <= wd_fire;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux

    // unmapped offsets read zero; reserved bits read zero
    assign rdata = sel_count ? count_q :
                   sel_match[0] ? match_q[0] :
                   sel_match[1] ? match_q[1] :
                   sel_match[2] ? match_q[2] :
                   sel_match[3] ? match_q[3] :
                   sel_wdarm ? {31'h0000_0000, wdarm_q} :
                   sel_flags ? chan_word(flags_q) :
                   sel_irqen ? chan_word(irqen_q) :
                   sel_imask ? chan_word(imask_q) :
                   32'h0000_0000;

endmodule

/* ostmr_props.sv */
// checker on the match timer top ports
// assumes one hclk domain and one wait state per bus transfer
`timescale 1ns/10ps
module ostmr_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [3:0] match_flag,
    input wire logic irq,
    input wire logic chip_reset_req
);
    logic w1_q, w2_q;
    wire tk = hsel && htrans[1] && hready;
    wire wr_win = w1_q || w2_q;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////
    // flag word write, kept over both edges of its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w1_q <= 1'b0;
            w2_q <= 1'b0;
        end else begin
            w1_q <= tk && hwrite && haddr[7:0] == 8'h18;
            w2_q <= w1_q;
        end
    end
    ////////////////////////
    // a taken read, then its single wait state
    sequence rd_of(logic [7:0] a);
        tk && !hwrite && haddr[7:0] == a ##1 !hreadyout;
    endsequence
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    wait_one_a: assert property (tk |=> !hreadyout ##1 hreadyout)
        else $error("wait state count wrong");
    flag_clear_a: assert property (|($past(match_flag) & ~match_flag) |->
        $past(wr_win) && (($past(match_flag) & ~match_flag & ~$past(hwdata[3:0])) == 4'h0))
        else $error("flag cleared without a one written");
    irq_flag_a: assert property (irq |-> match_flag != 4'h0)
        else $error("interrupt without a flag");
    flag_rsvd_a: assert property (rd_of(8'h18) |=> hreadyout && hrdata[31:4] == 28'h0)
        else $error("flag word upper bits set");
    arm_rsvd_a: assert property (rd_of(8'h14) |=> hreadyout && hrdata[31:1] == 31'h0)
        else $error("arm word upper bits set");
    unmapped_zero_a: assert property (rd_of(8'h40) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    fire_pulse_a: assert property (chip_reset_req |=> !chip_reset_req)
        else $error("chip reset request too long");
endmodule
bind ostmr_top ostmr_props ostmr_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .match_flag, .irq, .chip_reset_req);

/* ostmr_ahb_m.sv */
// processor side bus master model, single word transfers
// assumes hready is the one slave's hreadyout
`timescale 1ns/10ps
module ostmr_ahb_m (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    ////////////////////////
    // idle bus from time zero
    initial begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // hold each phase until hready, no assumed latency
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask
endmodule

/* ostmr_tb_top.sv */
// self-checking bench for the match timer
// assumes the bus model above and a 20 MHz hclk
`timescale 1ns/10ps
`include "ostmr_map.svh"
module ostmr_tb_top;
    logic hclk, hresetn, software_reset, sleep_entry, hsel, hwrite, hreadyout, hresp, irq;
    logic chip_reset_req, fired;
    logic [31:0] haddr, hwdata, hrdata, r, r2;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] match_flag;
    int n_errors, total_checks, cyc;
    ostmr_top ostmr_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .software_reset, .sleep_entry, .hreadyout, .hrdata, .hresp,
        .match_flag, .irq, .chip_reset_req);
    ostmr_ahb_m ostmr_ahb_m_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata);
    ////////////////////////
    // clock, hang limit and reset pulse catcher
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (chip_reset_req === 1'b1) fired = 1'b1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test;
        end
    end
    ////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ostmr_ahb_m_i.xfer(1'b1, a, d, x);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        ostmr_ahb_m_i.xfer(1'b0, a, 32'h0, d);
    endtask
    task do_reset;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    ////////////////////////
    task t_regs;
        rd(`OSTMR_OFS_WDARM, r);
        chk(r, 32'h0);
        rd(`OSTMR_OFS_FLAGS, r);
        chk(r, 32'h0);
        rd(8'h40, r);
        chk(r, 32'h0);
        for (int i = 0; i < 4; i++) wr(8'(i * 4), 32'ha5a5_0000 + 32'(i));
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), r);
            chk(r, 32'ha5a5_0000 + 32'(i));
        end
    endtask
    // load near all ones, so the span crosses the wrap
    task t_count;
        wr(`OSTMR_OFS_COUNT, 32'hffff_fff0);
        rd(`OSTMR_OFS_COUNT, r);
        chk(32'(r - 32'hffff_fff0 < 32'h4), 32'h1);
        repeat (1000) @(posedge hclk);
        rd(`OSTMR_OFS_COUNT, r2);
        chk(32'(r2 - r > 182 && r2 - r < 188), 32'h1);
        chk(32'(r2 < r), 32'h1);
    endtask
    task t_flags;
        wr(`OSTMR_OFS_IRQEN, 32'hb);
        wr(`OSTMR_OFS_IMASK, 32'h0);
        for (int i = 0; i < 4; i++) wr(8'(i * 4), 32'd30);
        fired = 1'b0;
        wr(`OSTMR_OFS_COUNT, 32'h0);
        repeat (300) @(posedge hclk);
        rd(`OSTMR_OFS_FLAGS, r);
        chk(r, 32'hb);
        chk({28'h0, match_flag}, 32'hb);
        chk({30'h0, fired, irq}, 32'h0);
        wr(`OSTMR_OFS_IMASK, 32'h2);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(`OSTMR_OFS_FLAGS, 32'hffff_fff0);
        rd(`OSTMR_OFS_FLAGS, r);
        chk(r, 32'hb);
        wr(`OSTMR_OFS_FLAGS, 32'h2);
        wr(`OSTMR_OFS_IRQEN, 32'h0);
        rd(`OSTMR_OFS_FLAGS, r);
        chk(r, 32'h9);
        chk({31'h0, irq}, 32'h0);
        wr(`OSTMR_OFS_FLAGS, 32'hf);
        rd(`OSTMR_OFS_FLAGS, r);
        chk(r, 32'h0);
    endtask
    // arm, fire, then each clearing source
    task t_dog;
        wr(`OSTMR_OFS_WDARM, 32'h1);
        wr(`OSTMR_OFS_WDARM, 32'h0);
        rd(`OSTMR_OFS_WDARM, r);
        chk(r, 32'h1);
        wr(`OSTMR_OFS_MATCH3, 32'd20);
        wr(`OSTMR_OFS_IRQEN, 32'h8);
        fired = 1'b0;
        wr(`OSTMR_OFS_COUNT, 32'h0);
        repeat (300) @(posedge hclk);
        chk({31'h0, fired}, 32'h1);
        rd(`OSTMR_OFS_WDARM, r);
        chk(r, 32'h0);
        for (int j = 0; j < 2; j++) begin
            wr(`OSTMR_OFS_WDARM, 32'h1);
            software_reset <= (j == 0);
            sleep_entry <= (j == 1);
            @(posedge hclk);
            software_reset <= 1'b0;
            sleep_entry <= 1'b0;
            rd(`OSTMR_OFS_WDARM, r);
            chk(r, 32'h0);
        end
        wr(`OSTMR_OFS_WDARM, 32'h1);
        wr(`OSTMR_OFS_COUNT, 32'h1000_0000);
        do_reset;
        rd(`OSTMR_OFS_WDARM, r);
        chk(r, 32'h0);
        rd(`OSTMR_OFS_COUNT, r);
        chk(32'(r >= 32'h1000_0000 && r < 32'h1000_0100), 32'h1);
    endtask
    task stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////
    initial begin
        hresetn = 1'b0;
        software_reset = 1'b0;
        sleep_entry = 1'b0;
        fired = 1'b0;
        n_errors = 0;
        total_checks = 0;
        cyc = 0;
        do_reset;
        t_regs;
        t_count;
        t_flags;
        t_dog;
        stop_test;
    end
endmodule
